/* rtl/timers_pkg.sv */
// Package of constants and types for the tick and wakeup timer block.
package timers_pkg;
	// ************************************************************
	// Tick timer
	// ************************************************************
	localparam int CNT_W = 32;
	localparam int MATCH_W = 28;
	localparam logic [31:0] TICK_RESET = 32'h0000_0000;
	localparam logic [27:0] MATCH_MAX = 28'hfff_ffff;
	localparam logic [27:0] MATCH_RESET = 28'h000_0000;

	// Tick modes as written by software; one-hot codes.
	typedef enum logic [3:0] {
		TM_OFF = 4'b0001,
		TM_SINGLE = 4'b0010,
		TM_RESTART = 4'b0100,
		TM_CONT = 4'b1000
	} tick_mode_e;

	// ************************************************************
	// Wakeup timers and calibration
	// ************************************************************
	localparam int NUM_WAKE = 2;
	localparam logic [31:0] WAKE_RESET = 32'h0000_0000;
	localparam logic [31:0] WAKE_ONE = 32'h0000_0001;
	localparam logic [31:0] REF_RESET = 32'h0000_0000;
	localparam int CAL_TIMER = 0;

	// The slow tick is sampled on the fast clock, so the rising edge of
	// that strobe is one 32 kHz period.
endpackage

/* rtl/wake_counter.sv */
// One 32-bit wakeup down-counter with expired status.
`timescale 1ns/1ps
`default_nettype none
module wake_counter (
	input wire logic mclk,
	input wire logic rst,
	input wire logic slow_tick,
	input wire logic sleep_hold,
	input wire logic load,
	input wire logic [31:0] load_value,
	input wire logic start,
	input wire logic stop,
	input wire logic irq_en,
	input wire logic status_read,
	output logic [31:0] count,
	output logic running,
	output logic expired,
	output logic zero_pulse,
	output logic irq
);
	logic [31:0] count_r, count_nxt;
	logic run_r, run_nxt;
	logic exp_r, exp_nxt;
	logic hit;

	always_comb begin
		count_nxt = count_r;
		run_nxt = run_r;
		hit = 1'b0;
		if (stop) begin
			run_nxt = 1'b0;
		end else if (start) begin
			run_nxt = 1'b1;
		end
		if (load) begin
			count_nxt = load_value;
		end else if (run_r && !stop && slow_tick && !sleep_hold) begin
			// Keeps going past zero and wraps, so service latency shows.
			count_nxt = count_r - timers_pkg::WAKE_ONE;
			hit = (count_r == timers_pkg::WAKE_ONE);
		end
		// A new expiry in the read cycle wins over the read-clear.
		exp_nxt = hit | (exp_r & ~status_read);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_r <= timers_pkg::WAKE_RESET;
			run_r <= 1'b0;
			exp_r <= 1'b0;
			zero_pulse <= 1'b0;
			irq <= 1'b0;
		end else begin
			count_r <= count_nxt;
			run_r <= run_nxt;
			exp_r <= exp_nxt;
			zero_pulse <= hit;
			irq <= hit & irq_en;
		end
	end

	assign count = count_r;
	assign running = run_r;
	assign expired = exp_r;

	wake_stop_hold_a: assert property (@(posedge mclk) disable iff (rst)
		stop |=> $stable(count_r) && !irq)
		else $error("wakeup count moved or irq after stop");
	wake_wrap_a: assert property (@(posedge mclk) disable iff (rst)
		run_r && !stop && !load && slow_tick && !sleep_hold
			&& count_r == 32'h0000_0000 |=> count_r == 32'hffff_ffff)
		else $error("wakeup counter did not wrap");
	wake_expire_a: assert property (@(posedge mclk) disable iff (rst)
		hit |=> exp_r && zero_pulse && count_r == 32'h0000_0000)
		else $error("expiry not flagged at zero");
	status_clear_a: assert property (@(posedge mclk) disable iff (rst)
		status_read && !hit |=> !exp_r)
		else $error("status read did not clear expired");
	wake_cv_c: cover property (@(posedge mclk) disable iff (rst) irq);
endmodule
`default_nettype wire

/* rtl/tick_wake_timers.sv */
// Top of the tick timer, two wakeup timers and the calibration counter.
// Functional notes
// - 32-bit tick up-counter, mode gated.
// - Match value 28 bits, 16MHz cycles.
// - Match raises irq only when enabled.
// - Mode write clears tick counter.
// - Single-shot halts after match until rewrite.
// - Restartable clears on match and continues.
// - Continuous counts past match uncleared.
// - Doze freezes the tick timer.
// - Two 32-bit down-counters on 32kHz.
// - Run in sleep unless disabled; never deep.
// - Zero sets expired, optional irq.
// - Counter keeps decrementing after zero.
// - Stop holds value, gives no irq.
// - Status read reports and clears expired.
// - Reference counter counts 16MHz while awake.
// - Calibration enable clears, then both start.
// - Timer 0 zero stops reference counter.
// - Twenty 32kHz periods give count 10000.
`timescale 1ns/1ps
`default_nettype none
module tick_wake_timers (
	input wire logic mclk,
	input wire logic rst,
	// Tick timer control.
	input wire logic tick_mode_wr,
	input wire logic [3:0] tick_mode,
	input wire logic [27:0] tick_match,
	input wire logic tick_irq_en,
	input wire logic cpu_doze,
	output logic [31:0] tick_count,
	output logic tick_match_hit,
	output logic tick_irq,
	// Wakeup timers.
	input wire logic slow_clk_en,
	input wire logic in_sleep,
	input wire logic in_deep_sleep,
	input wire logic [1:0] wake_sleep_dis,
	input wire logic [1:0] wake_load,
	input wire logic [31:0] wake_load_value,
	input wire logic [1:0] wake_start,
	input wire logic [1:0] wake_stop,
	input wire logic [1:0] wake_irq_en,
	input wire logic wake_status_rd,
	output logic [31:0] wake_count0,
	output logic [31:0] wake_count1,
	output logic [1:0] wake_running,
	output logic [1:0] wake_expired,
	output logic [1:0] wake_irq,
	// Calibration.
	input wire logic cal_enable,
	output logic [31:0] cal_ref_count,
	output logic cal_busy
);
	// ************************************************************
	// Tick timer
	// ************************************************************
	timers_pkg::tick_mode_e mode_r, mode_nxt;
	logic [31:0] tick_r, tick_nxt;
	logic halted_r, halted_nxt;
	logic match_r, match_nxt;
	logic irq_r, irq_nxt;
	logic [31:0] match_ext;
	logic is_match;

	function automatic timers_pkg::tick_mode_e decode_mode(
			input logic [3:0] code);
		unique case (code)
			4'b0010: decode_mode = timers_pkg::TM_SINGLE;
			4'b0100: decode_mode = timers_pkg::TM_RESTART;
			4'b1000: decode_mode = timers_pkg::TM_CONT;
			default: decode_mode = timers_pkg::TM_OFF;
		endcase
	endfunction

	// Only 28 bits reach the comparator; the top nibble is forced to zero.
	assign match_ext = {4'h0, tick_match & timers_pkg::MATCH_MAX};
	assign is_match = (tick_r == match_ext);

	always_comb begin
		mode_nxt = mode_r;
		tick_nxt = tick_r;
		halted_nxt = halted_r;
		match_nxt = 1'b0;
		irq_nxt = 1'b0;
		if (tick_mode_wr) begin
			mode_nxt = decode_mode(tick_mode);
			tick_nxt = timers_pkg::TICK_RESET;
			halted_nxt = 1'b0;
		end else if (!cpu_doze && mode_r != timers_pkg::TM_OFF
				&& !halted_r) begin
			if (is_match) begin
				match_nxt = 1'b1;
				irq_nxt = tick_irq_en;
			end
			unique case (mode_r)
				timers_pkg::TM_SINGLE: begin
					if (is_match) begin
						halted_nxt = 1'b1;
					end else begin
						tick_nxt = tick_r + 32'h0000_0001;
					end
				end
				timers_pkg::TM_RESTART: begin
					tick_nxt = is_match ? timers_pkg::TICK_RESET
						: tick_r + 32'h0000_0001;
				end
				timers_pkg::TM_CONT: begin
					tick_nxt = tick_r + 32'h0000_0001;
				end
				timers_pkg::TM_OFF: begin
					tick_nxt = tick_r;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_r <= timers_pkg::TM_OFF;
			tick_r <= timers_pkg::TICK_RESET;
			halted_r <= 1'b0;
			match_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			tick_r <= tick_nxt;
			halted_r <= halted_nxt;
			match_r <= match_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign tick_count = tick_r;
	assign tick_match_hit = match_r;
	assign tick_irq = irq_r;

	// ************************************************************
	// Wakeup timers
	// ************************************************************
	logic slow_d_r, slow_rise;
	logic [1:0] sleep_hold;
	logic [1:0] zero_pulse;
	logic [31:0] wcount [2];
	logic cal_rise;

	// The 32 kHz tick arrives as a level synchronous to mclk; one step per
	// rising edge keeps both timers in lockstep with the slow clock.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			slow_d_r <= 1'b0;
		end else begin
			slow_d_r <= slow_clk_en;
		end
	end
	assign slow_rise = slow_clk_en & ~slow_d_r;

	genvar gi;
	generate
		for (gi = 0; gi < timers_pkg::NUM_WAKE; gi++) begin : g_wake
			assign sleep_hold[gi] = in_deep_sleep
				| (in_sleep & wake_sleep_dis[gi]);
			wake_counter u_wake (
				.mclk(mclk),
				.rst(rst),
				.slow_tick(slow_rise),
				.sleep_hold(sleep_hold[gi]),
				.load(wake_load[gi]),
				.load_value(wake_load_value),
				.start(wake_start[gi]
					| (cal_rise && gi == timers_pkg::CAL_TIMER)),
				.stop(wake_stop[gi]),
				.irq_en(wake_irq_en[gi]),
				.status_read(wake_status_rd),
				.count(wcount[gi]),
				.running(wake_running[gi]),
				.expired(wake_expired[gi]),
				.zero_pulse(zero_pulse[gi]),
				.irq(wake_irq[gi])
			);
		end
	endgenerate

	assign wake_count0 = wcount[0];
	assign wake_count1 = wcount[1];

	// ************************************************************
	// Calibration reference counter
	// ************************************************************
	logic [31:0] ref_r, ref_nxt;
	logic cal_run_r, cal_run_nxt;
	logic cal_en_d_r;

	// A calibration start also starts wakeup timer 0 on the same edge, so
	// no software latency between the two enters the reference count.
	assign cal_rise = cal_enable & ~cal_en_d_r;

	always_comb begin
		ref_nxt = ref_r;
		cal_run_nxt = cal_run_r;
		if (cal_enable && !cal_en_d_r) begin
			ref_nxt = timers_pkg::REF_RESET;
			cal_run_nxt = 1'b1;
		end else if (cal_run_r) begin
			if (zero_pulse[timers_pkg::CAL_TIMER] || !cal_enable) begin
				cal_run_nxt = 1'b0;
			end else if (!in_sleep && !in_deep_sleep) begin
				ref_nxt = ref_r + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ref_r <= timers_pkg::REF_RESET;
			cal_run_r <= 1'b0;
			cal_en_d_r <= 1'b0;
		end else begin
			ref_r <= ref_nxt;
			cal_run_r <= cal_run_nxt;
			cal_en_d_r <= cal_enable;
		end
	end

	assign cal_ref_count = ref_r;
	assign cal_busy = cal_run_r;

	// ************************************************************
	// Checks
	// ************************************************************
	// Every property runs on mclk; the slow tick is only a strobe in this
	// domain, so one clock and one reset serve all of them.
	tick_mode_clear_a: assert property (@(posedge mclk) disable iff (rst)
		tick_mode_wr |=> tick_r == 32'h0000_0000)
		else $error("mode write did not clear tick counter");
	tick_irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
		tick_irq |-> match_r && $past(tick_irq_en))
		else $error("tick irq without match or enable");
	single_halt_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_SINGLE && halted_r && !tick_mode_wr
			|=> $stable(tick_r) && !match_r)
		else $error("single shot kept counting");
	restart_zero_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_RESTART && !halted_r && !cpu_doze
			&& is_match && !tick_mode_wr |=> tick_r == 32'h0000_0000)
		else $error("restartable did not clear on match");
	cont_pass_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_CONT && !cpu_doze && is_match
			&& !tick_mode_wr |=> tick_r == $past(tick_r) + 32'h0000_0001)
		else $error("continuous mode did not pass match");
	doze_freeze_a: assert property (@(posedge mclk) disable iff (rst)
		cpu_doze && !tick_mode_wr |=> $stable(tick_r))
		else $error("tick timer advanced in doze");
	cal_stop_a: assert property (@(posedge mclk) disable iff (rst)
		cal_run_r && zero_pulse[0] && !(cal_enable && !cal_en_d_r)
			|=> !cal_run_r ##1 $stable(ref_r))
		else $error("reference counter did not stop");
	cal_clear_a: assert property (@(posedge mclk) disable iff (rst)
		cal_enable && !cal_en_d_r |=> ref_r == 32'h0000_0000 && cal_run_r)
		else $error("calibration start did not clear reference");
	deep_hold_a: assert property (@(posedge mclk) disable iff (rst)
		in_deep_sleep && wake_load == 2'b00 |=> $stable(wcount[1]))
		else $error("wakeup timer ran in deep sleep");
	tick_irq_on_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r != timers_pkg::TM_OFF && !halted_r && !cpu_doze && !tick_mode_wr
			&& is_match && tick_irq_en |=> tick_irq && tick_match_hit)
		else $error("enabled match gave no tick irq");
	tick_off_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_OFF && !tick_mode_wr |=> $stable(tick_r))
		else $error("tick counter moved while off");
	tick_step_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r != timers_pkg::TM_OFF && !halted_r && !cpu_doze && !tick_mode_wr
			&& !is_match |=> tick_r == $past(tick_r) + 32'h0000_0001)
		else $error("tick counter did not step by one");
	single_stop_a: assert property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_SINGLE && !halted_r && !cpu_doze
			&& !tick_mode_wr && is_match |=> halted_r && $stable(tick_r))
		else $error("single shot did not stop at match");
	sleep_run_a: assert property (@(posedge mclk) disable iff (rst)
		in_sleep && !in_deep_sleep && !wake_sleep_dis[0] && wake_running[0]
			&& slow_rise && !wake_load[0] && !wake_stop[0]
			|=> wcount[0] == $past(wcount[0]) - 32'h0000_0001)
		else $error("wakeup timer 0 stalled in sleep");
	cal_count_a: assert property (@(posedge mclk) disable iff (rst)
		cal_run_r && cal_enable && !cal_rise && !zero_pulse[0]
			&& !in_sleep && !in_deep_sleep
			|=> ref_r == $past(ref_r) + 32'h0000_0001)
		else $error("reference counter missed a cycle");
	cal_go_a: assert property (@(posedge mclk) disable iff (rst)
		cal_rise && !wake_stop[0] |=> wake_running[0])
		else $error("calibration did not start wakeup timer 0");
	wake_irq_link_a: assert property (@(posedge mclk) disable iff (rst)
		wake_irq == (zero_pulse & $past(wake_irq_en)))
		else $error("wakeup irq does not follow expiry and enable");

	single_cv_c: cover property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_SINGLE && halted_r);
	restart_cv_c: cover property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_RESTART && tick_irq);
	cal_cv_c: cover property (@(posedge mclk) disable iff (rst)
		$fell(cal_run_r));
	cont_cv_c: cover property (@(posedge mclk) disable iff (rst)
		mode_r == timers_pkg::TM_CONT && tick_irq);
endmodule
`default_nettype wire

/* dv/tick_and_wakeup_timers_bench.sv */
// Self-checking bench for the tick timer, wakeup timers and calibration.
`timescale 1ns/1ps
`default_nettype none
module tick_and_wakeup_timers_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic tick_mode_wr = 1'b0;
	logic [3:0] tick_mode = 4'h1;
	logic [27:0] tick_match = 28'h0;
	logic tick_irq_en = 1'b0;
	logic cpu_doze = 1'b0;
	logic slow_clk_en = 1'b0;
	logic in_sleep = 1'b0;
	logic in_deep_sleep = 1'b0;
	logic [1:0] wake_sleep_dis = 2'h0;
	logic [1:0] wake_load = 2'h0;
	logic [31:0] wake_load_value = 32'h0;
	logic [1:0] wake_start = 2'h0;
	logic [1:0] wake_stop = 2'h0;
	logic [1:0] wake_irq_en = 2'h0;
	logic wake_status_rd = 1'b0;
	logic cal_enable = 1'b0;
	logic [31:0] tick_count, wake_count0, wake_count1, cal_ref_count;
	logic tick_match_hit, tick_irq, cal_busy;
	logic [1:0] wake_running, wake_expired, wake_irq;
	int err_count = 0;
	int num_checks = 0;
	int irq0_n = 0;
	int irq1_n = 0;
	tick_wake_timers dut_u (.mclk(mclk), .rst(rst),
		.tick_mode_wr(tick_mode_wr), .tick_mode(tick_mode),
		.tick_match(tick_match), .tick_irq_en(tick_irq_en),
		.cpu_doze(cpu_doze), .tick_count(tick_count),
		.tick_match_hit(tick_match_hit), .tick_irq(tick_irq),
		.slow_clk_en(slow_clk_en), .in_sleep(in_sleep),
		.in_deep_sleep(in_deep_sleep), .wake_sleep_dis(wake_sleep_dis),
		.wake_load(wake_load), .wake_load_value(wake_load_value),
		.wake_start(wake_start), .wake_stop(wake_stop),
		.wake_irq_en(wake_irq_en), .wake_status_rd(wake_status_rd),
		.wake_count0(wake_count0), .wake_count1(wake_count1),
		.wake_running(wake_running), .wake_expired(wake_expired),
		.wake_irq(wake_irq), .cal_enable(cal_enable),
		.cal_ref_count(cal_ref_count), .cal_busy(cal_busy));
	// ************************************************************
	// Clock, monitors and shared tasks
	// ************************************************************
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// Interrupt pulses last one cycle, so they are counted at every edge.
	always @(posedge mclk) begin
		if (wake_irq[0] === 1'b1) irq0_n++;
		if (wake_irq[1] === 1'b1) irq1_n++;
	end
	task check(input string name, input logic [63:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task set_mode(input logic [3:0] m, input logic [27:0] mt);
		tick_mode = m;
		tick_match = mt;
		tick_mode_wr = 1'b1;
		cyc(1);
		tick_mode_wr = 1'b0;
		check("tick_cleared", tick_count, 32'h0);
	endtask
	task wait_hit(output int n);
		n = 0;
		while (tick_match_hit !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
	endtask
	task wcmd(input logic [1:0] ld, st, sp, input logic [31:0] v);
		wake_load = ld;
		wake_start = st;
		wake_stop = sp;
		wake_load_value = v;
		cyc(1);
		wake_load = 2'h0;
		wake_start = 2'h0;
		wake_stop = 2'h0;
	endtask
	// One slow tick: a rising edge, then low for the rest of the period.
	task slow(input int p);
		slow_clk_en = 1'b1;
		cyc(1);
		slow_clk_en = 1'b0;
		cyc(p - 1);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_single;
		int n;
		tick_irq_en = 1'b0;
		set_mode(4'h2, 28'h5);
		wait_hit(n);
		check("single_delay", n, 32'h6);
		check("single_irq_off", {tick_irq, tick_count}, 33'h5);
		cyc(6);
		check("single_halt", {tick_match_hit, tick_count}, 33'h5);
		tick_irq_en = 1'b1;
		set_mode(4'h2, 28'h2);
		wait_hit(n);
		check("single_irq", {tick_irq, tick_count}, 33'h100000002);
	endtask
	task t_restart;
		int n;
		set_mode(4'h4, 28'h3);
		wait_hit(n);
		check("restart_wrap", {tick_irq, tick_count}, 33'h100000000);
		cyc(1);
		wait_hit(n);
		check("restart_period", n + 1, 32'h4);
	endtask
	task t_cont_doze;
		int n;
		set_mode(4'h8, 28'h3);
		wait_hit(n);
		check("cont_past", {tick_irq, tick_count}, 33'h100000004);
		cyc(3);
		check("cont_run", tick_count, 32'h7);
		cpu_doze = 1'b1;
		cyc(5);
		check("doze_hold", tick_count, 32'h7);
		cpu_doze = 1'b0;
		cyc(5);
		check("doze_resume", tick_count, 32'hc);
		set_mode(4'h1, 28'h3);
		cyc(4);
		check("off_hold", tick_count, 32'h0);
	endtask
	task t_wake_expire;
		wake_irq_en = 2'h1;
		wcmd(2'h1, 2'h0, 2'h0, 32'h3);
		wcmd(2'h0, 2'h1, 2'h0, 32'h0);
		repeat (3) slow(4);
		check("wake_zero", wake_count0, 32'h0);
		check("wake_stat", {wake_running, wake_expired}, 4'h5);
		check("wake_irq", irq0_n, 32'h1);
		slow(4);
		check("wake_wrap", wake_count0, 32'hffffffff);
		check("wake_sticky", wake_expired, 2'h1);
		check("wake_indep", wake_count1, 32'h0);
		wake_status_rd = 1'b1;
		cyc(1);
		wake_status_rd = 1'b0;
		cyc(1);
		check("wake_rd_clr", {wake_running, wake_expired}, 4'h4);
		wcmd(2'h0, 2'h0, 2'h1, 32'h0);
		slow(4);
		check("wake_stop0", wake_count0, 32'hffffffff);
	endtask
	task t_wake_stop_sleep;
		wake_irq_en = 2'h3;
		wcmd(2'h2, 2'h0, 2'h0, 32'h2);
		wcmd(2'h0, 2'h2, 2'h0, 32'h0);
		slow(4);
		wcmd(2'h0, 2'h0, 2'h2, 32'h0);
		repeat (3) slow(4);
		check("stop_hold", wake_count1, 32'h1);
		check("stop_quiet", {irq1_n[3:0], wake_running, wake_expired}, 8'h0);
		wcmd(2'h3, 2'h0, 2'h0, 32'ha);
		wcmd(2'h0, 2'h3, 2'h0, 32'h0);
		in_sleep = 1'b1;
		wake_sleep_dis = 2'h2;
		slow(4);
		check("sleep_run", {wake_count0, wake_count1}, 64'h9_0000000a);
		in_deep_sleep = 1'b1;
		slow(4);
		check("deep_hold", {wake_count0, wake_count1}, 64'h9_0000000a);
		{in_sleep, in_deep_sleep, wake_sleep_dis} = 4'h0;
		wcmd(2'h0, 2'h0, 2'h3, 32'h0);
	endtask
	// Twenty slow periods of 500 fast cycles model the nominal ratio.
	task t_cal;
		logic [31:0] ref_v;
		wake_irq_en = 2'h0;
		wcmd(2'h1, 2'h0, 2'h0, 32'h0000_0014);
		wake_status_rd = 1'b1;
		cyc(1);
		wake_status_rd = 1'b0;
		cal_enable = 1'b1;
		cyc(2);
		check("cal_busy", cal_busy, 1'b1);
		check("cal_zeroed", cal_ref_count, 32'h1);
		check("cal_t0_run", wake_running[0], 1'b1);
		// The first slow edge comes one full period after the start.
		cyc(498);
		repeat (20) slow(500);
		ref_v = cal_ref_count;
		check("cal_done", {cal_busy, wake_count0}, 33'h0);
		check("cal_value", ref_v, 32'h0000_2710);
		cyc(20);
		check("cal_hold", cal_ref_count, ref_v);
		cal_enable = 1'b0;
	endtask
	// ************************************************************
	// Main sequence and end of run
	// ************************************************************
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		cyc(10);
		rst = 1'b0;
		cyc(1);
		check("reset_out", {tick_count, wake_expired, cal_busy}, 35'h0);
		t_single();
		t_restart();
		t_cont_doze();
		t_wake_expire();
		t_wake_stop_sleep();
		t_cal();
		close_out();
	end
	// The run needs about 11000 cycles; this limit leaves wide margin.
	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
